/* core/ppol_map.svh */
`ifndef PPOL_MAP_SVH
`define PPOL_MAP_SVH

// Register offsets
`define PPOL_OFF_INPUT_PINS   6'h00
`define PPOL_OFF_DIRECTION    6'h01
`define PPOL_OFF_OUTPUT_DATA  6'h02
`define PPOL_OFF_PULLUP_EN    6'h03
`define PPOL_OFF_CONTROL      6'h0c

// Field positions and reset values
`define PPOL_BBM_BIT          1
`define PPOL_PIN_BITS         4
`define PPOL_RST_DIRECTION    4'h0
`define PPOL_RST_OUTPUT_DATA  4'h0
`define PPOL_RST_PULLUP_EN    4'h0
`define PPOL_RST_BBM          1'h0
`define PPOL_RST_SYNC         4'h0

`endif

/* core/ppol_pkg.sv */
package ppol_pkg;

	// Per-pin override bundle
	typedef struct packed {
		logic pullup_override_en;
		logic pullup_override_val;
		logic dir_override_en;
		logic dir_override_val;
		logic value_override_en;
		logic value_override_val;
		logic toggle_override_en;
		logic input_en_override_en;
		logic input_en_override_val;
	} ppol_ovr_t;

	// Register bus request
	typedef struct packed {
		logic [5:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} ppol_bus_t;

	// Break-before-make sequencing
	typedef enum logic [0:0] {
		PPOL_BBM_IDLE = 1'b0,
		PPOL_BBM_HOLD = 1'b1
	} ppol_bbm_state_t;

endpackage

/* core/ppol_port.sv */
// Implementation choice: strobed register access.
`include "ppol_map.svh"

// Function
// R1: Pin3 reset-disable forces pullup on, driver off
// R2: Pin3 input-enable override enable terms
// R3: Pin3 input-enable override value AND
// R4: Pin2 clock-out fuse drives system clock
// R5: Pin2 input-enable override enable terms
// R6: Pin2 input-enable override value terms
// R7: Pin1 external clock forces pullup off, driver off
// R8: Pin1 value override from clock or compare-B
// R9: Pin1 input-enable override enable and value
// R10: Pin0 input override; toggle override always zero
// R11: Pin3 feeds pin-change source 3
// R12: Control reserved bits read zero
// R13: Control bit1 enables break-before-make
// R14: New output inserts one tri-state cycle
// R15: Output data register, four bits, reset zero
// R16: Direction register, four bits, reset zero
// R17: Input pins register returns pin levels
// R18: Pullup follows override or pullup bit
// R19: Driver follows override or direction bit
// R20: Pin value follows override or data bit
// R21: Input enable follows override or sleep state
// R22: Pin0 value overridden by compare-A output
module ppol_port
	import ppol_pkg::*;
(
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       srst,
	input  wire logic       clk_en,
	// Register port
	input  wire logic [5:0] bus_addr,
	input  wire logic [7:0] bus_wdata,
	input  wire logic       bus_wr,
	input  wire logic       bus_rd,
	output logic      [7:0] bus_rdata,
	// Configuration and alternate function sources
	input  wire logic       reset_pin_disable,
	input  wire logic       clock_output_fuse,
	input  wire logic       ext_main_clock_sel,
	input  wire logic       power_down_state,
	input  wire logic       sleep_input_off,
	input  wire logic       pin_change_irq_en,
	input  wire logic [3:0] pin_change_mask,
	input  wire logic [3:0] analog_disable,
	input  wire logic       ext_irq0,
	input  wire logic       compare_a_en,
	input  wire logic       compare_a_wave,
	input  wire logic       compare_b_en,
	input  wire logic       compare_b_wave,
	input  wire logic       sys_clock_level,
	// Pads
	input  wire logic [3:0] pin_in,
	output logic      [3:0] pin_out,
	output logic      [3:0] pin_oe,
	output logic      [3:0] pin_pullup,
	// Alternate digital inputs
	output logic      [3:0] alt_digital_input,
	output logic      [3:0] pin_change_src
);

	// --------------------------------------------------------------
	// Registers
	// --------------------------------------------------------------
	ppol_bus_t       bus;
	logic      [3:0] out_reg;
	logic      [3:0] dir_reg;
	logic      [3:0] pue_reg;
	logic            bbm_reg;
	logic      [3:0] drv_dir_reg;
	logic      [3:0] bbm_hold_reg;
	ppol_bbm_state_t bbm_state_reg;
	logic      [3:0] sync1_reg;
	logic      [3:0] sync2_reg;
	logic      [3:0] sync3_reg;
	logic      [3:0] in_reg;
	logic      [3:0] in_en;
	ppol_ovr_t       ovr [4];

	assign bus = '{addr: bus_addr, wdata: bus_wdata, wr: bus_wr, rd: bus_rd};

	function automatic logic sel(input logic en, input logic val, input logic dflt);
		return en ? val : dflt;
	endfunction

	function automatic logic hit(input ppol_bus_t b, input logic [5:0] off);
		return b.wr && (b.addr == off);
	endfunction

	// Read mux; unmapped offsets and the unused upper nibbles read zero
	function automatic logic [7:0] rd_mux(
		input logic [5:0] a,
		input logic [3:0] pins,
		input logic [3:0] dir,
		input logic [3:0] data,
		input logic [3:0] pue,
		input logic       bbm
	);
		case (a)
			`PPOL_OFF_INPUT_PINS:  return {4'h0, pins}; // R17
			`PPOL_OFF_DIRECTION:   return {4'h0, dir}; // R16
			`PPOL_OFF_OUTPUT_DATA: return {4'h0, data}; // R15
			`PPOL_OFF_PULLUP_EN:   return {4'h0, pue};
			`PPOL_OFF_CONTROL:     return {6'h00, bbm, 1'b0}; // R12
			default:               return 8'h00;
		endcase
	endfunction

	// --------------------------------------------------------------
	// Override table
	// --------------------------------------------------------------
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			// Fields a pin does not use stay zero
			ovr[i] = '0;
		end
		// Pin 0
		ovr[0].pullup_override_en   = 1'b0; // R22
		ovr[0].pullup_override_val  = 1'b0; // R22
		ovr[0].dir_override_en      = 1'b0; // R22
		ovr[0].dir_override_val     = 1'b0; // R22
		ovr[0].value_override_en    = compare_a_en; // R22
		ovr[0].value_override_val   = compare_a_wave; // R22
		ovr[0].input_en_override_en = (pin_change_mask[0] & pin_change_irq_en)
			| analog_disable[0]; // R10
		ovr[0].input_en_override_val = pin_change_mask[0] & pin_change_irq_en; // R10
		// Pin 1
		ovr[1].pullup_override_en  = ext_main_clock_sel; // R7
		ovr[1].pullup_override_val = 1'b0; // R7
		ovr[1].dir_override_en     = ext_main_clock_sel; // R7
		ovr[1].dir_override_val    = 1'b0; // R7
		ovr[1].value_override_en   = ext_main_clock_sel | compare_b_en; // R8
		ovr[1].value_override_val  = ext_main_clock_sel & compare_b_wave; // R8
		ovr[1].input_en_override_en = ext_main_clock_sel
			| (pin_change_mask[1] & pin_change_irq_en) | analog_disable[1]; // R9
		ovr[1].input_en_override_val = (ext_main_clock_sel & power_down_state)
			| (ext_main_clock_sel & pin_change_mask[1] & pin_change_irq_en); // R9
		// Pin 2
		ovr[2].pullup_override_en  = clock_output_fuse; // R4
		ovr[2].pullup_override_val = 1'b0; // R4
		ovr[2].dir_override_en     = clock_output_fuse; // R4
		ovr[2].dir_override_val    = 1'b1; // R4
		ovr[2].value_override_en   = clock_output_fuse; // R4
		ovr[2].value_override_val  = sys_clock_level; // R4
		ovr[2].input_en_override_en = (pin_change_mask[2] & pin_change_irq_en)
			| analog_disable[2] | ext_irq0; // R5
		ovr[2].input_en_override_val = (pin_change_mask[2] & pin_change_irq_en)
			| ext_irq0; // R6
		// Pin 3
		ovr[3].pullup_override_en  = reset_pin_disable; // R1
		ovr[3].pullup_override_val = 1'b1; // R1
		ovr[3].dir_override_en     = reset_pin_disable; // R1
		ovr[3].dir_override_val    = 1'b0; // R1
		ovr[3].value_override_en   = 1'b0; // R1
		ovr[3].value_override_val  = 1'b0; // R1
		ovr[3].input_en_override_en = reset_pin_disable
			| (pin_change_mask[3] & pin_change_irq_en) | analog_disable[3]; // R2
		ovr[3].input_en_override_val = reset_pin_disable & pin_change_mask[3]
			& pin_change_irq_en; // R3
		for (int i = 0; i < 4; i++) begin
			ovr[i].toggle_override_en = 1'b0; // R10
		end
	end

	// --------------------------------------------------------------
	// Output data register
	// --------------------------------------------------------------
	// Writing ones to the input register toggles the data bits
	always_ff @(posedge clk) begin
		if (srst) begin
			out_reg <= `PPOL_RST_OUTPUT_DATA; // R15
		end else if (clk_en) begin
			if (hit(bus, `PPOL_OFF_OUTPUT_DATA)) begin
				out_reg <= bus.wdata[3:0]; // R15
			end else if (hit(bus, `PPOL_OFF_INPUT_PINS)) begin
				out_reg <= out_reg ^ bus.wdata[3:0]; // R17
			end
		end
	end

	// --------------------------------------------------------------
	// Direction register
	// --------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (srst) begin
			dir_reg <= `PPOL_RST_DIRECTION; // R16
		end else if (clk_en) begin
			if (hit(bus, `PPOL_OFF_DIRECTION)) begin
				dir_reg <= bus.wdata[3:0]; // R16
			end
		end
	end

	// --------------------------------------------------------------
	// Pull-up enable register
	// --------------------------------------------------------------
	// Pull-up stays as set even while the pin drives
	always_ff @(posedge clk) begin
		if (srst) begin
			pue_reg <= `PPOL_RST_PULLUP_EN;
		end else if (clk_en) begin
			if (hit(bus, `PPOL_OFF_PULLUP_EN)) begin
				pue_reg <= bus.wdata[3:0];
			end
		end
	end

	// --------------------------------------------------------------
	// Control register
	// --------------------------------------------------------------
	// Only the break-before-make bit is stored; the rest reads zero
	always_ff @(posedge clk) begin
		if (srst) begin
			bbm_reg <= `PPOL_RST_BBM;
		end else if (clk_en) begin
			if (hit(bus, `PPOL_OFF_CONTROL)) begin
				bbm_reg <= bus.wdata[`PPOL_BBM_BIT]; // R13
			end
		end
	end

	// --------------------------------------------------------------
	// Break-before-make
	// --------------------------------------------------------------
	// A bit turning to output is held tri-state for one cycle
	always_ff @(posedge clk) begin
		if (srst) begin
			drv_dir_reg   <= `PPOL_RST_DIRECTION;
			bbm_hold_reg  <= 4'h0;
			bbm_state_reg <= PPOL_BBM_IDLE;
		end else if (clk_en) begin
			case (bbm_state_reg)
				PPOL_BBM_IDLE: begin
					bbm_hold_reg <= 4'h0;
					if (bbm_reg && (|(dir_reg & ~drv_dir_reg))) begin
						drv_dir_reg   <= dir_reg & drv_dir_reg; // R14
						bbm_hold_reg  <= dir_reg & ~drv_dir_reg; // R14
						bbm_state_reg <= PPOL_BBM_HOLD;
					end else begin
						drv_dir_reg <= dir_reg;
					end
				end
				PPOL_BBM_HOLD: begin
					// Held bits join the driven set one cycle late
					drv_dir_reg   <= dir_reg; // R14
					bbm_hold_reg  <= 4'h0;
					bbm_state_reg <= PPOL_BBM_IDLE;
				end
				default: begin
					bbm_state_reg <= PPOL_BBM_IDLE;
				end
			endcase
		end
	end

	// --------------------------------------------------------------
	// Input synchroniser
	// --------------------------------------------------------------
	// The first stage may go metastable, so only the second reads it
	always_ff @(posedge clk) begin
		if (srst) begin
			sync1_reg <= `PPOL_RST_SYNC;
			sync2_reg <= `PPOL_RST_SYNC;
			sync3_reg <= `PPOL_RST_SYNC;
		end else if (clk_en) begin
			sync1_reg <= pin_in;
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
		end
	end

	// --------------------------------------------------------------
	// Input qualification
	// --------------------------------------------------------------
	// A level counts once two stages agree; a disabled input reads zero
	always_ff @(posedge clk) begin
		if (srst) begin
			in_reg <= `PPOL_RST_SYNC;
		end else if (clk_en) begin
			for (int i = 0; i < 4; i++) begin
				if (sync2_reg[i] == sync3_reg[i]) begin
					in_reg[i] <= sync3_reg[i] & in_en[i]; // R21
				end
			end
		end
	end

	// --------------------------------------------------------------
	// Input enable
	// --------------------------------------------------------------
	// Sleep gates every input that no alternate function holds open
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			in_en[i] = sel(ovr[i].input_en_override_en, ovr[i].input_en_override_val,
				~sleep_input_off); // R21
		end
	end

	// --------------------------------------------------------------
	// Driver enable
	// --------------------------------------------------------------
	// Registered so every output is a flop; costs one cycle of latency
	always_ff @(posedge clk) begin
		if (srst) begin
			pin_oe <= 4'h0;
		end else if (clk_en) begin
			for (int i = 0; i < 4; i++) begin
				pin_oe[i] <= sel(ovr[i].dir_override_en, ovr[i].dir_override_val,
					drv_dir_reg[i] & ~bbm_hold_reg[i]); // R19
			end
		end
	end

	// --------------------------------------------------------------
	// Pad value
	// --------------------------------------------------------------
	// The toggle term is tied low but kept so the path stays complete
	always_ff @(posedge clk) begin
		if (srst) begin
			pin_out <= 4'h0;
		end else if (clk_en) begin
			for (int i = 0; i < 4; i++) begin
				pin_out[i] <= sel(ovr[i].value_override_en, ovr[i].value_override_val,
					out_reg[i] ^ ovr[i].toggle_override_en); // R20
			end
		end
	end

	// --------------------------------------------------------------
	// Pull-up
	// --------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (srst) begin
			pin_pullup <= 4'h0;
		end else if (clk_en) begin
			for (int i = 0; i < 4; i++) begin
				pin_pullup[i] <= sel(ovr[i].pullup_override_en, ovr[i].pullup_override_val,
					pue_reg[i]); // R18
			end
		end
	end

	// --------------------------------------------------------------
	// Alternate inputs
	// --------------------------------------------------------------
	// Alternate digital inputs see the synchronised pad even while reads are gated; pin-change sources take the gated level
	always_ff @(posedge clk) begin
		if (srst) begin
			alt_digital_input <= 4'h0;
			pin_change_src    <= 4'h0;
		end else if (clk_en) begin
			alt_digital_input <= sync3_reg;
			pin_change_src    <= in_reg; // R11
		end
	end

	// --------------------------------------------------------------
	// Read data
	// --------------------------------------------------------------
	// Read data stand for one cycle and return to zero after it
	always_ff @(posedge clk) begin
		if (srst) begin
			bus_rdata <= 8'h00;
		end else if (clk_en) begin
			if (bus.rd) begin
				bus_rdata <= rd_mux(bus.addr, in_reg, dir_reg, out_reg, pue_reg, bbm_reg); // R17
			end else begin
				bus_rdata <= 8'h00;
			end
		end
	end

endmodule

/* dv/ppol_pads.sv */
module ppol_pads (
	// Device side
	input wire logic       clk,
	input wire logic [3:0] pin_out,
	input wire logic [3:0] pin_oe,
	input wire logic [3:0] pin_pullup,
	// External drivers
	input wire logic [3:0] ext_en,
	input wire logic [3:0] ext_val,
	// Resolved pad level
	output logic     [3:0] pin_in
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] float_reg = 4'h0;

	// A floating pad keeps changing, so a stale level never looks driven
	always @(posedge clk) begin
		float_reg <= ~float_reg;
	end
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			pin_in[i] = pin_oe[i] ? pin_out[i] : ext_en[i] ? ext_val[i] : pin_pullup[i] | float_reg[i];
		end
	end
endmodule

/* dv/ppol_port_assertions.sv */
module ppol_chk (
	// Clock, reset and register port
	input wire logic       clk,
	input wire logic       srst,
	input wire logic [5:0] bus_addr,
	input wire logic [7:0] bus_wdata,
	input wire logic       bus_wr,
	input wire logic       bus_rd,
	input wire logic [7:0] bus_rdata,
	// Alternate sources
	input wire logic       reset_pin_disable,
	input wire logic       clock_output_fuse,
	input wire logic       ext_main_clock_sel,
	input wire logic       compare_a_en,
	input wire logic       compare_a_wave,
	input wire logic       compare_b_en,
	// Pads
	input wire logic [3:0] pin_out,
	input wire logic [3:0] pin_oe,
	input wire logic [3:0] pin_pullup
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	sequence dir0_set;
		bus_wr && bus_addr == 6'h01 && bus_wdata[0] && !pin_oe[0];
	endsequence
	sequence dir0_on;
		##[3:4] pin_oe[0];
	endsequence

	rst_pin_force_a: assert property (reset_pin_disable[*3] |-> pin_pullup[3] && !pin_oe[3])
		else $error("pin3 pull-up or driver wrong");
	clk_out_drive_a: assert property (clock_output_fuse[*3] |-> pin_oe[2] && !pin_pullup[2])
		else $error("pin2 clock output not driven");
	ext_clk_force_a: assert property (ext_main_clock_sel[*3] |-> !pin_pullup[1] && !pin_oe[1])
		else $error("pin1 not released");
	cmp_b_zero_a: assert property ((compare_b_en && !ext_main_clock_sel)[*3] |-> !pin_oe[1] || !pin_out[1])
		else $error("pin1 value override wrong");
	cmp_a_follow_a: assert property ((compare_a_en && $stable(compare_a_wave))[*3] |-> !pin_oe[0] || pin_out[0] == compare_a_wave)
		else $error("pin0 not following compare output");
	dir_drive_on_a: assert property (dir0_set |-> dir0_on)
		else $error("pin0 driver late");
	ctrl_rsvd_zero_a: assert property (bus_rd && bus_addr == 6'h0c |=> bus_rdata[7:2] == 6'h00 && !bus_rdata[0])
		else $error("reserved control bits set");
	reg_nibble_zero_a: assert property (bus_rd && bus_addr inside {6'h01, 6'h02} |=> bus_rdata[7:4] == 4'h0)
		else $error("upper nibble not zero");
endmodule

/* dv/tb.sv */
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic       clk = 1'b0, srst = 1'b1, bus_wr = 1'b0, bus_rd = 1'b0, clk_en = 1'b1;
	logic       reset_pin_disable = 1'b0, clock_output_fuse = 1'b0, ext_main_clock_sel = 1'b0;
	logic       compare_a_en = 1'b0, compare_a_wave = 1'b0, compare_b_en = 1'b0;
	logic       compare_b_wave = 1'b0, sys_clock_level = 1'b0, pin_change_irq_en = 1'b0;
	logic       power_down_state = 1'b0, sleep_input_off = 1'b0, ext_irq0 = 1'b0;
	logic [3:0] pin_change_mask = 4'h0, analog_disable = 4'h0, ext_en = 4'h0, ext_val = 4'h0;
	logic [5:0] bus_addr = 6'h00;
	logic [7:0] bus_wdata = 8'h00, bus_rdata;
	logic [3:0] pin_in, pin_out, pin_oe, pin_pullup, alt_digital_input, pin_change_src;
	int         n_fail = 0, checked = 0, cyc = 0;

	ppol_port ppol_port_inst (.*);
	ppol_pads ppol_pads_inst (.*);

	always #2.5 clk = ~clk;
	// Tests need well under a thousand cycles
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			n_fail++;
			close_out();
		end
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// An idle cycle after each strobe keeps one assignment per time step
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		bus_wr <= 1'b1;
		bus_addr <= a;
		bus_wdata <= d;
		@(posedge clk);
		bus_wr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [5:0] a, input logic [7:0] exp);
		bus_rd <= 1'b1;
		bus_addr <= a;
		@(posedge clk);
		bus_rd <= 1'b0;
		#1 chk(bus_rdata, exp);
		@(posedge clk);
	endtask

	task automatic t_regs();
		rd(6'h01, 8'h00);
		rd(6'h02, 8'h00);
		wr(6'h01, 8'hff);
		rd(6'h01, 8'h0f);
		wr(6'h02, 8'ha5);
		rd(6'h02, 8'h05);
		clk_en <= 1'b0;
		wr(6'h02, 8'h0f);
		clk_en <= 1'b1;
		rd(6'h02, 8'h05);
		wr(6'h0c, 8'hff);
		rd(6'h0c, 8'h02);
		wr(6'h3f, 8'hff);
		rd(6'h3f, 8'h00);
		wr(6'h01, 8'h00);
		wr(6'h0c, 8'h00);
		$display("test regs done");
	endtask
	task automatic t_bbm();
		wr(6'h01, 8'h01);
		@(posedge clk);
		#1 chk(8'(pin_oe), 8'h01);
		@(posedge clk);
		wr(6'h01, 8'h00);
		wr(6'h0c, 8'h02);
		wr(6'h01, 8'h01);
		#1 chk(8'(pin_oe), 8'h00);
		@(posedge clk);
		#1 chk(8'(pin_oe), 8'h00);
		@(posedge clk);
		#1 chk(8'(pin_oe), 8'h01);
		@(posedge clk);
		wr(6'h01, 8'h00);
		wr(6'h0c, 8'h00);
		$display("test bbm done");
	endtask
	task automatic t_pins();
		pin_change_irq_en <= 1'b1;
		pin_change_mask <= 4'h5;
		ext_en <= 4'hf;
		ext_val <= 4'ha;
		repeat (8) @(posedge clk);
		rd(6'h00, 8'h0a);
		#1 chk(8'(pin_change_src), 8'h0a);
		chk(8'(alt_digital_input), 8'h0a);
		pin_change_mask <= 4'hf;
		ext_val <= 4'hf;
		repeat (8) @(posedge clk);
		rd(6'h00, 8'h05);
		sleep_input_off <= 1'b1;
		pin_change_mask <= 4'h0;
		repeat (8) @(posedge clk);
		rd(6'h00, 8'h00);
		sleep_input_off <= 1'b0;
		ext_en <= 4'h0;
		$display("test pins done");
	endtask
	task automatic t_ovr();
		wr(6'h03, 8'h0f);
		#1 chk(8'(pin_pullup), 8'h0f);
		wr(6'h01, 8'h0f);
		wr(6'h02, 8'h0f);
		compare_a_en <= 1'b1;
		compare_b_en <= 1'b1;
		compare_b_wave <= 1'b1;
		repeat (3) @(posedge clk);
		#1 chk(8'(pin_out), 8'h0c);
		reset_pin_disable <= 1'b1;
		clock_output_fuse <= 1'b1;
		ext_main_clock_sel <= 1'b1;
		sys_clock_level <= 1'b1;
		repeat (3) @(posedge clk);
		#1 chk({pin_oe, pin_pullup}, 8'h59);
		chk(8'(pin_out[2]), 8'h01);
		$display("test overrides done");
	endtask

	task automatic close_out();
		$display("counts: %0d checked, %0d mismatches", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	initial begin
		repeat (5) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		t_regs();
		t_bbm();
		t_pins();
		t_ovr();
		close_out();
	end
endmodule

bind ppol_port ppol_chk ppol_chk_inst (.*);
